/* File: dcp_controller.sv */
// Controller driving a 64K x 1 dynamic RAM through its strobes and pins.
// Assumes a 200 MHz clk; the RAM data-out pin arrives asynchronously.
// Behaviour
// RULE_01: Wait 100 us, then eight row cycles.
// RULE_02: Write enable stays high after read strobes.
// RULE_03: Read data sampled after column access time.
// RULE_04: Data-in valid at column or write fall.
// RULE_05: Early write: enable low before column strobe.
// RULE_06: Read-write: late write, data read first.
// RULE_07: Never mix write timings; no indeterminate cycles.
// RULE_08: Refresh: row strobe only, column strobe high.
// RULE_09: Refresh every row within 2 ms.
// RULE_10: Row half then column half, eight lines.
// RULE_11: One data bit in, one out.
// RULE_12: Switch address between row and column falls.
`include "dcp_defines.svh"

module dcp_controller
  import dcp_pkg::*;
#(
  parameter int POWERUP_CYC = `DCP_POWERUP_CYC,
  parameter int REFRESH_CYC = `DCP_REFRESH_INT_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        reqValid,
  input  wire dcp_op_e     reqOp,
  input  wire logic [15:0] reqAddr,
  input  wire logic        reqData,
  output logic             reqReady,
  output logic             rspValid,
  output logic             rspData,
  output logic             ready,
  output logic             rowStrobe_n,
  output logic             colStrobe_n,
  output logic             writeEnable_n,
  output logic [7:0]       memAddr,
  output logic             memDataIn,
  input  wire logic        memDataOut
);

  ////////////////////////////////////////////////////////////////////////////
  // State, timers, pin synchroniser
  dcp_state_e  state_q, state_d;
  dcp_op_e     op_q;
  logic [15:0] addr_q;
  logic        data_q;
  logic        refresh_q;
  logic [3:0]  initCnt_q;
  logic [6:0]  refRow_q;
  logic        refPend_q;
  logic        powerLoaded_q;
  logic        sync1_q, sync2_q;
  logic        timLoad, timZero, refZero;
  logic [15:0] timValue;

  dcp_counter #(.WIDTH(16)) phaseTimer (
    .clk(clk), .reset_n(reset_n), .load(timLoad), .value(timValue), .zero(timZero)
  );
  // Period is value plus one; two spare cycles a row absorb one access in flight
  dcp_counter #(.WIDTH(16)) refreshTimer (
    .clk(clk), .reset_n(reset_n), .load(refZero), .value(16'(REFRESH_CYC - 3)), .zero(refZero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing decisions
  wire inInit    = (initCnt_q != 4'(`DCP_INIT_CYCLES));
  wire startRef  = refPend_q || inInit;
  wire startReq  = reqValid && !inInit && !refPend_q;
  wire isWrite   = (op_q == DCP_OP_WRITE);
  wire isRmw     = (op_q == DCP_OP_RMW);
  wire idleNow   = (state_q == DCP_ST_IDLE);

  always_comb begin
    state_d  = state_q;
    timLoad  = 1'b0;
    timValue = '0;
    unique case (state_q)
      DCP_ST_POWERUP: if (!powerLoaded_q) begin
        timLoad  = 1'b1;
        timValue = 16'(POWERUP_CYC);
      end else if (timZero) begin                               // RULE_01
        state_d = DCP_ST_IDLE;
      end
      DCP_ST_IDLE: if (startRef || startReq) begin
        state_d  = DCP_ST_ROW;
        timLoad  = 1'b1;
        timValue = 16'(`DCP_ROW_HOLD_CYC);
      end
      DCP_ST_ROW: if (timZero) begin                            // RULE_12
        if (refresh_q) begin                                    // RULE_08
          state_d  = DCP_ST_HOLD;
          timLoad  = 1'b1;
          timValue = 16'(`DCP_RAS_WIDTH_CYC - `DCP_ROW_HOLD_CYC);
        end else begin
          state_d  = DCP_ST_COL;
          timLoad  = 1'b1;
          timValue = 16'(`DCP_ROW_COL_CYC - `DCP_ROW_HOLD_CYC);
        end
      end
      DCP_ST_COL: if (timZero) begin
        state_d  = DCP_ST_CAS;
        timLoad  = 1'b1;
        // Reads wait out the row access limit plus the synchroniser delay
        timValue = isRmw ? 16'(`DCP_ROW_WR_DLY_CYC - `DCP_ROW_COL_CYC) // RULE_06
                         : 16'(`DCP_ROW_ACCESS_CYC - `DCP_ROW_COL_CYC + `DCP_SYNC_MARGIN_CYC);
      end
      DCP_ST_CAS: if (timZero) begin
        if (isRmw) begin
          state_d  = DCP_ST_WRITE;
          timLoad  = 1'b1;
          timValue = 16'(`DCP_WR_PULSE_CYC);
        end else begin
          state_d  = DCP_ST_HOLD;
          timLoad  = 1'b1;
          timValue = 16'(`DCP_READ_HOLD_CYC);
        end
      end
      DCP_ST_WRITE: if (timZero) begin
        state_d  = DCP_ST_HOLD;
        timLoad  = 1'b1;
        timValue = 16'(`DCP_READ_HOLD_CYC);
      end
      DCP_ST_HOLD: if (timZero) begin
        state_d  = DCP_ST_PRECH;
        timLoad  = 1'b1;
        timValue = 16'(`DCP_RAS_PRECH_CYC);
      end
      DCP_ST_PRECH: if (timZero) begin
        state_d = DCP_ST_IDLE;
      end
      default: state_d = DCP_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  wire entering   = idleNow && (startRef || startReq);
  // Row strobe falls one cycle after the row address goes out
  wire rowLow_d   = (state_d != DCP_ST_IDLE) && (state_d != DCP_ST_PRECH)
                    && (state_d != DCP_ST_POWERUP) && !entering;     // RULE_12
  wire colPhase_d = (state_d == DCP_ST_CAS) || (state_d == DCP_ST_WRITE)
                    || ((state_d == DCP_ST_HOLD) && !refresh_q);
  wire colLow_d   = colPhase_d && !refresh_q;                        // RULE_08
  wire earlyWr_d  = isWrite && !refresh_q && (state_d != DCP_ST_IDLE)
                    && (state_d != DCP_ST_PRECH);                    // RULE_05
  wire lateWr_d   = isRmw && !refresh_q && (state_d == DCP_ST_WRITE);// RULE_06
  wire weLow_d    = earlyWr_d || lateWr_d;                           // RULE_07
  wire useCol_d   = (state_d == DCP_ST_COL) || colPhase_d;           // RULE_10
  wire [15:0] nextAddr = entering ? (startRef ? {9'h000, refRow_q} : reqAddr) : addr_q;
  wire [7:0] addr_d = useCol_d ? nextAddr[15:8] : nextAddr[7:0];      // RULE_12
  wire sampleNow  = timZero && !refresh_q && ((state_q == DCP_ST_WRITE)
                    || ((state_q == DCP_ST_CAS) && (op_q == DCP_OP_READ))); // RULE_03

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= memDataOut;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q       <= DCP_ST_POWERUP;
      op_q          <= DCP_OP_READ;
      addr_q        <= 16'h0000;
      data_q        <= 1'b0;
      refresh_q     <= 1'b0;
      initCnt_q     <= 4'h0;
      refRow_q      <= 7'h00;
      refPend_q     <= 1'b0;
      rowStrobe_n   <= 1'b1;
      colStrobe_n   <= 1'b1;
      writeEnable_n <= 1'b1;
      memAddr       <= 8'h00;
      memDataIn     <= 1'b0;
      reqReady      <= 1'b0;
      rspValid      <= 1'b0;
      rspData       <= 1'b0;
      ready         <= 1'b0;
    end else begin
      state_q       <= state_d;
      rowStrobe_n   <= !rowLow_d;
      colStrobe_n   <= !colLow_d;
      writeEnable_n <= !weLow_d;                                     // RULE_02
      memAddr       <= addr_d;
      memDataIn     <= entering ? reqData : data_q;                  // RULE_04
      reqReady      <= 1'b0;
      rspValid      <= sampleNow;
      if (sampleNow) begin
        rspData <= sync2_q;                                          // RULE_11
      end
      ready <= ready || (!inInit && (state_d == DCP_ST_IDLE));
      if (refZero && (state_q != DCP_ST_POWERUP)) begin
        refPend_q <= 1'b1;                                           // RULE_09
      end else if (entering && startRef && !inInit) begin
        refPend_q <= 1'b0;
      end
      if (entering) begin
        refresh_q <= startRef;
        op_q      <= startRef ? DCP_OP_READ : reqOp;
        addr_q    <= nextAddr;
        data_q    <= reqData;
        reqReady  <= !startRef;
        if (startRef) begin
          refRow_q <= refRow_q + 7'h01;
          if (inInit) begin
            initCnt_q <= initCnt_q + 4'h1;                           // RULE_01
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up wait loaded once after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      powerLoaded_q <= 1'b0;
    end else begin
      powerLoaded_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol checks on the RAM pins
  refresh_cas_high_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
    refresh_q && !rowStrobe_n |-> colStrobe_n)
    else $error("column strobe low during refresh");
  read_we_high_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
    (op_q == DCP_OP_READ) && !(rowStrobe_n && colStrobe_n) |-> writeEnable_n)
    else $error("write enable low during read");
  row_addr_stable_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
    $fell(rowStrobe_n) |-> $stable(memAddr))
    else $error("row address moved at row strobe fall");
  col_addr_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    $fell(colStrobe_n) |-> $stable(memAddr) && (memAddr == addr_q[15:8]))
    else $error("column address wrong at column strobe fall");
  early_write_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
    $fell(colStrobe_n) && (op_q == DCP_OP_WRITE) |-> !writeEnable_n && !$past(writeEnable_n))
    else $error("early write enable not set up");
  late_write_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    $fell(writeEnable_n) && !colStrobe_n |-> (op_q == DCP_OP_RMW) && !rowStrobe_n)
    else $error("late write outside read-modify-write");
  data_in_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    !writeEnable_n && !rowStrobe_n |-> (memDataIn == data_q))
    else $error("data-in not held during write");
  init_before_cas_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    !ready |-> colStrobe_n)
    else $error("column strobe before initialisation");
  read_done_c: cover property (@(posedge clk) disable iff (!reset_n)
    rspValid && (op_q == DCP_OP_READ));
  rmw_done_c: cover property (@(posedge clk) disable iff (!reset_n)
    rspValid && (op_q == DCP_OP_RMW));
  early_write_c: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(colStrobe_n) && (op_q == DCP_OP_WRITE));
  refresh_c: cover property (@(posedge clk) disable iff (!reset_n)
    refresh_q && $fell(rowStrobe_n) && ready);
endmodule // dcp_controller

/* File: dcp_defines.svh */
// Timing constants for the 64K x 1 dynamic RAM controller.
// Assumes a 200 MHz clk; times are given in ns, us or ms and converted to cycles; the sync margin is given in cycles.
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH

`define DCP_CLK_PERIOD_NS     5
`define DCP_POWERUP_US        100
`define DCP_POWERUP_CYC       ((`DCP_POWERUP_US * 1000 + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_INIT_CYCLES       8
`define DCP_REFRESH_MS        2
`define DCP_REFRESH_ROWS      128
// Refresh interval for one row, rounded down so all rows fit in the period
`define DCP_REFRESH_INT_CYC   ((`DCP_REFRESH_MS * 1000000 / `DCP_REFRESH_ROWS) / `DCP_CLK_PERIOD_NS)
`define DCP_RAS_PRECH_NS      190
`define DCP_RAS_PRECH_CYC     ((`DCP_RAS_PRECH_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_RAS_WIDTH_NS      250
`define DCP_RAS_WIDTH_CYC     ((`DCP_RAS_WIDTH_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_ROW_HOLD_NS       45
`define DCP_ROW_HOLD_CYC      ((`DCP_ROW_HOLD_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_ROW_COL_NS        55
`define DCP_ROW_COL_CYC       ((`DCP_ROW_COL_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_CAS_WIDTH_NS      145
`define DCP_CAS_WIDTH_CYC     ((`DCP_CAS_WIDTH_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_COL_ACCESS_NS     145
`define DCP_COL_ACCESS_CYC    ((`DCP_COL_ACCESS_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_COL_WR_DLY_NS     70
`define DCP_COL_WR_DLY_CYC    ((`DCP_COL_WR_DLY_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_ROW_WR_DLY_NS     195
`define DCP_ROW_WR_DLY_CYC    ((`DCP_ROW_WR_DLY_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_WR_PULSE_NS       75
`define DCP_WR_PULSE_CYC      ((`DCP_WR_PULSE_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_READ_HOLD_NS      40
`define DCP_READ_HOLD_CYC     ((`DCP_READ_HOLD_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
`define DCP_ROW_ACCESS_NS     250
`define DCP_ROW_ACCESS_CYC    ((`DCP_ROW_ACCESS_NS + `DCP_CLK_PERIOD_NS - 1) / `DCP_CLK_PERIOD_NS)
// Extra column-phase cycles so the two-flop synchroniser holds settled data
`define DCP_SYNC_MARGIN_CYC   3

`endif

/* File: dcp_pkg.sv */
// Types for the 64K x 1 dynamic RAM controller.
// Assumes nothing beyond the defines header.
package dcp_pkg;
  typedef enum logic [1:0] {DCP_OP_READ, DCP_OP_WRITE, DCP_OP_RMW} dcp_op_e;
  typedef enum logic [3:0] {
    DCP_ST_POWERUP, DCP_ST_IDLE, DCP_ST_ROW, DCP_ST_COL, DCP_ST_CAS,
    DCP_ST_WRITE, DCP_ST_HOLD, DCP_ST_PRECH
  } dcp_state_e;
endpackage

/* File: dcp_counter.sv */
// Down counter that loads a value and flags when it reaches zero.
// Assumes the load value fits WIDTH bits.
module dcp_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value,
  output logic                  zero
);
  logic [WIDTH-1:0] count_q;

  assign zero = (count_q == '0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= value;
    end else if (!zero) begin
      count_q <= count_q - 1'b1;
    end
  end
endmodule // dcp_counter

/* File: dcp_dram_model.sv */
// Behavioural 64K x 1 dynamic RAM on the controller's far side.
// Assumes it sees only the RAM pins; times in ns; counts protocol faults.
module dcp_dram_model #(
  parameter int ROW_ACC_NS = 250,
  parameter int COL_ACC_NS = 145,
  parameter int FIRST_NS   = 100,
  parameter int REFR_NS    = 2000000
) (
  input  wire logic       rowStrobe_n,
  input  wire logic       colStrobe_n,
  input  wire logic       writeEnable_n,
  input  wire logic [7:0] memAddr,
  input  wire logic       memDataIn,
  output logic            memDataOut,
  output logic [7:0]      faultCount,
  output logic [7:0]      rasCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cells [65536];
  logic [7:0] rowQ;
  logic [7:0] colQ;
  logic       early = 1'b0;
  logic       readBit = 1'b0;
  realtime    rasT = 0;
  realtime    casT = 0;
  realtime    seenT [128] = '{default: -1.0};
  initial begin
    memDataOut = 1'b0;
    faultCount = 8'h00;
    rasCount = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  always @(negedge rowStrobe_n) begin
    rowQ = memAddr;
    rasT = $realtime;
    if (rasT < FIRST_NS) faultCount++;
    if (seenT[rowQ[6:0]] >= 0 && rasT - seenT[rowQ[6:0]] > REFR_NS) faultCount++;
    seenT[rowQ[6:0]] = rasT;
    if (rasCount != 8'hFF) rasCount++;
  end
  always @(negedge colStrobe_n) begin
    colQ = memAddr;
    casT = $realtime;
    early = !writeEnable_n;
    if (rowStrobe_n || rasCount < 8'h08) faultCount++;
    readBit = cells[{colQ, rowQ}];
    if (early) cells[{colQ, rowQ}] = memDataIn;
  end
  always @(negedge writeEnable_n) begin
    if (!colStrobe_n && !rowStrobe_n && !early) begin
      if ($realtime - casT < 70 || $realtime - rasT < 195) faultCount++;
      cells[{colQ, rowQ}] = memDataIn;
    end
  end
  // Output held off until both access limits have run out
  always begin
    @(negedge colStrobe_n);
    #(COL_ACC_NS);
    if ($realtime - rasT < ROW_ACC_NS) #(ROW_ACC_NS - ($realtime - rasT));
    if (!colStrobe_n && !early) memDataOut = readBit;
  end
  // Released line shows the inverse of its last value
  always @(posedge colStrobe_n) memDataOut = ~memDataOut;
endmodule  // dcp_dram_model

/* File: test_dram_64kx1_cycle_protocol.sv */
// Self-checking bench for the 64K x 1 dynamic RAM controller.
// Assumes dcp_pkg, dcp_counter, dcp_controller and dcp_dram_model are compiled first.
module test_dram_64kx1_cycle_protocol
  import dcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POWERUP = 20;
  localparam int REFRESH = 200;
  localparam logic [15:0] ADDRS [5] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'hFF00, 16'h5A3C};
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reqValid = 1'b0;
  dcp_op_e     reqOp = DCP_OP_READ;
  logic [15:0] reqAddr = 16'h0000;
  logic        reqData = 1'b0;
  logic        reqReady, rspValid, rspData, ready;
  logic        rowStrobe_n, colStrobe_n, writeEnable_n, memDataIn, memDataOut;
  logic [7:0]  memAddr, faultCount, rasCount;
  int          mismatches = 0;
  int          checked = 0;
  always #2.5 clk = ~clk;
  dcp_controller #(.POWERUP_CYC(POWERUP), .REFRESH_CYC(REFRESH)) dcp_controller_i (
    .clk, .reset_n, .reqValid, .reqOp, .reqAddr, .reqData, .reqReady, .rspValid,
    .rspData, .ready, .rowStrobe_n, .colStrobe_n, .writeEnable_n, .memAddr,
    .memDataIn, .memDataOut);
  // Power-up and refresh limits scaled to the shortened POWERUP and REFRESH counts
  dcp_dram_model #(
    .FIRST_NS(5 * (20 + POWERUP)), .REFR_NS(128 * REFRESH * 5)
  ) dcp_dram_model_i (
    .rowStrobe_n, .colStrobe_n, .writeEnable_n, .memAddr, .memDataIn,
    .memDataOut, .faultCount, .rasCount);
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check_val(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wait_for(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== 1'b1 && n < 4000);
    if (s !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // Holds the request until accepted, then waits for read data if any
  task automatic access(input dcp_op_e op, input logic [15:0] a, input logic d);
    @(posedge clk);
    reqValid <= 1'b1;
    reqOp    <= op;
    reqAddr  <= a;
    reqData  <= d;
    wait_for(reqReady);
    @(posedge clk);
    reqValid <= 1'b0;
    if (op != DCP_OP_WRITE)
      wait_for(rspValid);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic test_init();
    check_val({7'h0, ready}, 8'h00);
    wait_for(ready);
    check_val({7'h0, rasCount >= 8'h08}, 8'h01);
    $display("test_init done");
  endtask
  task automatic test_write_read();
    foreach (ADDRS[i]) access(DCP_OP_WRITE, ADDRS[i], i[0]);
    foreach (ADDRS[i]) begin
      access(DCP_OP_READ, ADDRS[i], 1'b0);
      check_val({7'h0, rspData}, {7'h0, i[0]});
    end
    $display("test_write_read done");
  endtask
  task automatic test_rmw();
    access(DCP_OP_RMW, 16'h5A3C, 1'b1);
    check_val({7'h0, rspData}, 8'h00);
    access(DCP_OP_RMW, 16'h5A3C, 1'b0);
    check_val({7'h0, rspData}, 8'h01);
    access(DCP_OP_READ, 16'h5A3C, 1'b1);
    check_val({7'h0, rspData}, 8'h00);
    $display("test_rmw done");
  endtask
  task automatic test_refresh();
    repeat (2 * 128 * REFRESH + 100) @(posedge clk);
    access(DCP_OP_READ, 16'hFFFF, 1'b0);
    check_val({7'h0, rspData}, 8'h01);
    check_val(faultCount, 8'h00);
    $display("test_refresh done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    test_init();
    test_write_read();
    test_rmw();
    test_refresh();
    print_verdict();
  end
endmodule  // test_dram_64kx1_cycle_protocol
